// >>> htc_params.svh
`ifndef HTC_PARAMS_SVH
`define HTC_PARAMS_SVH
// Fine time: one 25 ns period split into 32 bins of about 0.78 ns.
`define HTC_FINE_PERIOD_PS 25000
`define HTC_FINE_BINS 32
`define HTC_BIN_PS (`HTC_FINE_PERIOD_PS / `HTC_FINE_BINS)
`define HTC_HALF_BIN 6'h10
`define HTC_MAX_BIN 6'h1F
`define HTC_MASK17 32'h0001FFFF
`define HTC_MASK16 32'h0000FFFF
// Shortest pulse and system clock; the cycle count rounds up, at least one.
`define HTC_SYS_PERIOD_NS 10
`define HTC_MIN_PULSE_NS 10
`define HTC_MIN_PULSE_CYC ((`HTC_MIN_PULSE_NS + `HTC_SYS_PERIOD_NS - 1) / `HTC_SYS_PERIOD_NS)
`define HTC_TAPS 32
`define HTC_CW 12
`define HTC_DEPTH 4
`define HTC_PAIR_ROOM 3'h2
`define HTC_COARSE_RST 12'h000
// APB register byte addresses.
`define HTC_ADDR_CTRL 12'h000
`define HTC_ADDR_OFFSET 12'h004
`define HTC_ADDR_STATUS 12'h008
`define HTC_ADDR_MASK 12'h00C
`define HTC_ADDR_INFO 12'h010
`define HTC_CTRL_RST 32'h00000010
`define HTC_CTRL_EN_BIT 4
`define HTC_CTRL_RELOAD_BIT 8
`define HTC_ST_ACC 0
`define HTC_ST_DROP 1
`define HTC_ST_WR 2
`define HTC_ST_W 3
`endif

// >>> htc_pkg.sv
package htc_pkg;
  typedef enum logic [1:0] {HTC_M_PAIR, HTC_M_LEAD, HTC_M_TRAIL, HTC_M_BOTH} htc_mode_t;
  typedef enum logic [1:0] {HTC_T_FULL, HTC_T_DUAL, HTC_T_HALF} htc_tap_t;
  typedef enum logic [1:0] {HTC_K_PAIR, HTC_K_LEAD, HTC_K_TRAIL} htc_kind_t;
  typedef struct packed {
    logic [31:0] taps;
    logic [11:0] ca;
    logic [11:0] cb;
    logic trail;
  } htc_edge_t;
endpackage : htc_pkg

// >>> htc_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none
interface htc_fifo_if;
  import htc_pkg::*;
  logic push;
  htc_edge_t wdata;
  logic [1:0] pop_n;
  htc_edge_t head;
  htc_edge_t next;
  logic [2:0] count;
  modport ctrl (output push, output wdata, output pop_n, input head, input next, input count);
  modport mem (input push, input wdata, input pop_n, output head, output next, output count);
endinterface : htc_fifo_if
`default_nettype wire

// >>> htc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
`include "htc_params.svh"
module htc_fifo
  import htc_pkg::*;
(
  input wire logic i_clk_sys, // System clock.
  input wire logic i_reset,   // Asynchronous reset, active high.
  htc_fifo_if.mem f           // Edge record port.
);
  htc_edge_t mem_q [`HTC_DEPTH];
  logic [1:0] wr_q;
  logic [1:0] rd_q;
  logic [2:0] cnt_q;

  always_ff @(posedge i_clk_sys) begin
    if (f.push) begin
      mem_q[wr_q] <= f.wdata;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      wr_q <= 2'h0;
      rd_q <= 2'h0;
      cnt_q <= 3'h0;
    end else begin
      wr_q <= wr_q + 2'(f.push);
      rd_q <= rd_q + f.pop_n;
      cnt_q <= cnt_q + 3'(f.push) - 3'(f.pop_n);
    end
  end

  assign f.head = mem_q[rd_q];
  assign f.next = mem_q[rd_q + 2'h1];
  assign f.count = cnt_q;

  fifo_bound_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    cnt_q <= 3'(`HTC_DEPTH)) else $error("Channel buffer holds more than four edges.");
endmodule : htc_fifo
`default_nettype wire

// >>> htc_channel.sv
// Summary of operation
// - Pulse-width mode pairs leading and trailing edge.
// - Leading-only, trailing-only or both unpaired modes.
// - Fine time has 32 bins per 25 ns.
// - Capture holds 32 taps, two 12-bit counts.
// - Two coarse counts half a cycle apart.
// - Fine time picks the valid coarse count.
// - Coarse counter loads programmable offset on a CTRL reload write.
// - Times stored only when a hit occurs.
// - Buffer holds four edges, two full pairs.
// - Both edges of 10 ns pulses captured.
// - Unpaired modes use all four entries.
// - Hit with full buffer is dropped entirely.
// - Completed measurement raises a write request.
// - Write request is synchronised before arbitration.
// - Dual-edge option takes fine time from 17 taps.
// - Double-rate option halves the fine tap count.
// - Serviced record: binary fine, chosen coarse, channel.
`timescale 1ns/1ps
`default_nettype none
`include "htc_params.svh"
module htc_channel
  import htc_pkg::*;
#(
  parameter logic [4:0] CHANNEL = 5'h00
) (
  input wire logic i_clk_sys,                // System clock, 100 MHz.
  input wire logic i_reset,                  // Asynchronous reset, active high.
  input wire logic i_hit,                    // Discriminated hit level.
  input wire logic [`HTC_TAPS-1:0] i_taps,   // Delay-line tap snapshot.
  input wire logic i_wr_grant,               // Grant from channel arbitration.
  output logic o_wr_req,                     // Write request to first level buffer.
  output logic [4:0] o_rec_chan,             // Channel number of the record.
  output logic [1:0] o_rec_kind,             // Pair, leading or trailing record.
  output logic [4:0] o_rec_lead_fine,        // Binary fine time, first edge.
  output logic [`HTC_CW-1:0] o_rec_lead_crs, // Coarse time, first edge.
  output logic [4:0] o_rec_trl_fine,         // Binary fine time, trailing edge.
  output logic [`HTC_CW-1:0] o_rec_trl_crs,  // Coarse time, trailing edge.
  input wire logic psel,                     // APB select.
  input wire logic penable,                  // APB enable.
  input wire logic pwrite,                   // APB write.
  input wire logic [11:0] paddr,             // APB byte address.
  input wire logic [31:0] pwdata,            // APB write data.
  output logic [31:0] prdata,                // APB read data.
  output logic pready,                       // APB ready.
  output logic pslverr,                      // APB error on unmapped address.
  output logic o_irq                         // Level interrupt.
);
  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] htc_ones(input logic [31:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int k = 0; k < `HTC_TAPS; k++) begin
      n = n + 6'(v[k]);
    end
    return n;
  endfunction : htc_ones

  function automatic logic [4:0] htc_fine_bin(input logic [31:0] taps, input htc_tap_t tm);
    logic [5:0] n;
    n = 6'h00;
    unique case (tm)
      HTC_T_FULL: n = htc_ones(taps);
      HTC_T_DUAL: n = 6'(htc_ones(taps & `HTC_MASK17) << 1);
      HTC_T_HALF: n = 6'(htc_ones(taps & `HTC_MASK16) << 1);
      default: n = htc_ones(taps);
    endcase
    return (n > `HTC_MAX_BIN) ? 5'(`HTC_MAX_BIN) : n[4:0];
  endfunction : htc_fine_bin

  function automatic logic [11:0] htc_sel_coarse(input logic [4:0] bin, input htc_edge_t e);
    return (6'(bin) >= `HTC_HALF_BIN) ? e.ca : e.cb;
  endfunction : htc_sel_coarse

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [11:0] offset_q;
  logic [`HTC_ST_W-1:0] status_q;
  logic [`HTC_ST_W-1:0] mask_q;
  logic [31:0] prdata_q;
  logic wr_en;
  logic rd_setup;
  logic addr_ok;
  htc_mode_t mode;
  htc_tap_t tap_mode;
  logic enable;
  logic reload;

  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign addr_ok = (paddr == `HTC_ADDR_CTRL) || (paddr == `HTC_ADDR_OFFSET) || (paddr == `HTC_ADDR_STATUS)
                   || (paddr == `HTC_ADDR_MASK) || (paddr == `HTC_ADDR_INFO);
  assign mode = htc_mode_t'(ctrl_q[1:0]);
  assign tap_mode = htc_tap_t'(ctrl_q[3:2]);
  assign enable = ctrl_q[`HTC_CTRL_EN_BIT];
  assign reload = wr_en && (paddr == `HTC_ADDR_CTRL) && pwdata[`HTC_CTRL_RELOAD_BIT];

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      ctrl_q <= `HTC_CTRL_RST;
      offset_q <= `HTC_COARSE_RST;
      mask_q <= '0;
    end else if (wr_en) begin
      if (paddr == `HTC_ADDR_CTRL) begin
        ctrl_q <= {27'h0000000, pwdata[4:0]};
      end
      if (paddr == `HTC_ADDR_OFFSET) begin
        offset_q <= pwdata[11:0];
      end
      if (paddr == `HTC_ADDR_MASK) begin
        mask_q <= pwdata[`HTC_ST_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Coarse counters
  // ----------------------------------------------------------------
  // Counter B trails A by one step; it stands for the copy that changes half a
  // cycle away from A, so one of the two is settled at any hit instant.
  logic [11:0] coarse_a_q;
  logic [11:0] coarse_b_q;
  logic load_q;

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      load_q <= 1'b1;
      coarse_a_q <= `HTC_COARSE_RST;
      coarse_b_q <= `HTC_COARSE_RST;
    end else begin
      load_q <= 1'b0;
      if (load_q || reload) begin
        coarse_a_q <= offset_q;
        coarse_b_q <= offset_q;
      end else begin
        coarse_a_q <= coarse_a_q + 12'h001;
        coarse_b_q <= coarse_a_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Edge capture into the channel buffer
  // ----------------------------------------------------------------
  htc_fifo_if fi ();
  logic hit_q;
  logic lead_open_q;
  logic rise;
  logic fall;
  logic acc_rise;
  logic acc_fall;
  logic drop;
  logic full;

  htc_fifo u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .f(fi.mem)
  );

  assign full = fi.count == 3'(`HTC_DEPTH);
  assign rise = enable && i_hit && !hit_q;
  assign fall = enable && !i_hit && hit_q;

  always_comb begin
    acc_rise = 1'b0;
    acc_fall = 1'b0;
    unique case (mode)
      HTC_M_PAIR: begin
        acc_rise = rise && (fi.count <= `HTC_PAIR_ROOM);
        acc_fall = fall && lead_open_q;
      end
      HTC_M_LEAD: acc_rise = rise && !full;
      HTC_M_TRAIL: acc_fall = fall && !full;
      HTC_M_BOTH: begin
        acc_rise = rise && !full;
        acc_fall = fall && !full;
      end
    endcase
  end

  assign drop = (rise && !acc_rise && mode != HTC_M_TRAIL) || (fall && !acc_fall && mode != HTC_M_LEAD);
  assign fi.push = acc_rise || acc_fall;
  assign fi.wdata = '{taps: i_taps, ca: coarse_a_q, cb: coarse_b_q, trail: acc_fall};

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      hit_q <= 1'b0;
      lead_open_q <= 1'b0;
    end else begin
      hit_q <= i_hit;
      if (acc_rise && mode == HTC_M_PAIR) begin
        lead_open_q <= 1'b1;
      end else if (fall || mode != HTC_M_PAIR) begin
        lead_open_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Request, synchroniser and record
  // ----------------------------------------------------------------
  logic pend_q;
  logic req_s1_q;
  logic req_s2_q;
  logic rec_ready;
  logic pend_set;
  logic grant;
  logic pair_q;
  logic [4:0] bin_h;
  logic [4:0] bin_n;

  assign rec_ready = (mode == HTC_M_PAIR) ? (fi.count >= 3'h2) : (fi.count != 3'h0);
  assign pend_set = rec_ready && !pend_q && !req_s2_q;
  assign o_wr_req = req_s2_q && pend_q;
  assign grant = o_wr_req && i_wr_grant;
  assign fi.pop_n = grant ? (pair_q ? 2'h2 : 2'h1) : 2'h0;
  assign bin_h = htc_fine_bin(fi.head.taps, tap_mode);
  assign bin_n = htc_fine_bin(fi.next.taps, tap_mode);

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      pend_q <= 1'b0;
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
    end else begin
      req_s1_q <= pend_q;
      req_s2_q <= req_s1_q;
      if (grant) begin
        pend_q <= 1'b0;
      end else if (pend_set) begin
        pend_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      pair_q <= 1'b0;
      o_rec_chan <= 5'h00;
      o_rec_kind <= 2'h0;
      o_rec_lead_fine <= 5'h00;
      o_rec_lead_crs <= 12'h000;
      o_rec_trl_fine <= 5'h00;
      o_rec_trl_crs <= 12'h000;
    end else if (pend_set) begin
      pair_q <= mode == HTC_M_PAIR;
      o_rec_chan <= CHANNEL;
      o_rec_lead_fine <= bin_h;
      o_rec_lead_crs <= htc_sel_coarse(bin_h, fi.head);
      if (mode == HTC_M_PAIR) begin
        o_rec_kind <= HTC_K_PAIR;
        o_rec_trl_fine <= bin_n;
        o_rec_trl_crs <= htc_sel_coarse(bin_n, fi.next);
      end else begin
        o_rec_kind <= fi.head.trail ? HTC_K_TRAIL : HTC_K_LEAD;
        o_rec_trl_fine <= 5'h00;
        o_rec_trl_crs <= 12'h000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status, interrupt and APB read
  // ----------------------------------------------------------------
  logic [`HTC_ST_W-1:0] ev;
  logic [`HTC_ST_W-1:0] clr;

  assign ev = {grant, drop, fi.push};
  assign clr = (wr_en && paddr == `HTC_ADDR_STATUS) ? pwdata[`HTC_ST_W-1:0] : '0;

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~clr) | ev;
    end
  end

  assign o_irq = |(status_q & mask_q);

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      prdata_q <= 32'h00000000;
    end else if (rd_setup) begin
      unique case (paddr)
        `HTC_ADDR_CTRL: prdata_q <= ctrl_q;
        `HTC_ADDR_OFFSET: prdata_q <= {20'h00000, offset_q};
        `HTC_ADDR_STATUS: prdata_q <= {29'h00000000, status_q};
        `HTC_ADDR_MASK: prdata_q <= {29'h00000000, mask_q};
        `HTC_ADDR_INFO: prdata_q <= {4'h0, coarse_a_q, 13'h0000, fi.count};
        default: prdata_q <= 32'h00000000;
      endcase
    end
  end

  assign prdata = prdata_q;
  assign pready = penable;
  assign pslverr = psel && penable && !addr_ok;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  drop_no_push_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    drop |-> !fi.push) else $error("Dropped hit was stored.");
  store_on_hit_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    fi.push |-> (rise || fall)) else $error("Store without hit edge.");
  req_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_wr_req && !i_wr_grant |=> o_wr_req) else $error("Request dropped before grant.");
  req_sync_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    $rose(o_wr_req) |-> $past(pend_q, 2) && $past(pend_q)) else $error("Request not synchronised.");
  pop_grant_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (fi.pop_n != 2'h0) |-> grant) else $error("Entry removed without grant.");
  pair_pop_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    grant && pair_q |-> fi.pop_n == 2'h2 && o_rec_kind == HTC_K_PAIR) else $error("Pair not removed whole.");
  coarse_sel_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    pend_set |=> o_rec_lead_crs == ((6'(o_rec_lead_fine) >= `HTC_HALF_BIN) ? $past(fi.head.ca) : $past(fi.head.cb)))
    else $error("Wrong coarse count chosen.");
  coarse_load_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    reload |=> coarse_a_q == $past(offset_q) ##1 coarse_a_q == $past(offset_q, 2) + 12'h001)
    else $error("Coarse offset not loaded.");
  short_pulse_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (rise && mode == HTC_M_PAIR && fi.count == 3'h0 && !pend_q) ##1 fall |-> fi.push && fi.wdata.trail)
    else $error("Short pulse trailing edge lost.");
  req_rise_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    pend_set |-> ##3 o_wr_req) else $error("Completed measurement not requested.");
  trail_lead_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    fi.push && fi.wdata.trail && mode == HTC_M_PAIR |-> lead_open_q)
    else $error("Trailing edge stored without its leading edge.");

  pair_wr_c: cover property (@(posedge i_clk_sys) disable iff (i_reset) grant && pair_q);
  single_wr_c: cover property (@(posedge i_clk_sys) disable iff (i_reset) grant && !pair_q);
  drop_c: cover property (@(posedge i_clk_sys) disable iff (i_reset) drop && full);
  short_c: cover property (@(posedge i_clk_sys) disable iff (i_reset) rise ##1 fall);
  half_tap_c: cover property (@(posedge i_clk_sys) disable iff (i_reset) fi.push && tap_mode == HTC_T_HALF);
endmodule : htc_channel
`default_nettype wire

// >>> htc_arb_model.sv
`timescale 1ns/1ps
`default_nettype none
module htc_arb_model (
  input wire logic i_clk_sys,    // System clock.
  input wire logic i_reset,      // Reset, active high.
  input wire logic i_wr_req,     // Channel write request.
  input wire logic [40:0] i_rec, // Record standing with the request.
  input wire logic i_stall,      // Hold off all grants.
  input wire logic [3:0] i_delay, // Cycles of request before grant, less one.
  output logic o_wr_grant        // One-cycle grant.
);
  // ----------------------------------------
  // Arbitration and first level buffer
  // ----------------------------------------
  logic [3:0] wait_q;
  logic [40:0] rec_q[$];
  int n_drop = 0;
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_wr_grant <= 1'b0;
      wait_q <= 4'h0;
    end else if (o_wr_grant) begin
      rec_q.push_back(i_rec);
      o_wr_grant <= 1'b0;
      wait_q <= 4'h0;
    end else if (i_wr_req && !i_stall) begin
      if (wait_q == i_delay) begin
        o_wr_grant <= 1'b1;
      end
      wait_q <= wait_q + 4'h1;
    end else if (wait_q != 4'h0 && !i_wr_req) begin
      // A request withdrawn before its grant is counted.
      n_drop <= n_drop + 1;
    end
  end
endmodule : htc_arb_model
`default_nettype wire

// >>> tb_hit_time_capture_channel_buffer.sv
`timescale 1ns/1ps
`default_nettype none
`include "htc_params.svh"
module tb_hit_time_capture_channel_buffer;
  import htc_pkg::*;
  localparam logic [4:0] CH = 5'h13;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hit = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic stall = 1'b0;
  logic [3:0] dly = 4'h0;
  logic [31:0] taps = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic req, grant, pready, pslverr, irq, err;
  wire [40:0] rec;
  logic [40:0] r;
  int n_mismatch = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  htc_channel #(.CHANNEL(CH)) uut (.i_clk_sys(clk), .i_reset(rst), .i_hit(hit), .i_taps(taps),
    .i_wr_grant(grant), .o_wr_req(req), .o_rec_chan(rec[40:36]), .o_rec_kind(rec[35:34]),
    .o_rec_lead_fine(rec[33:29]), .o_rec_lead_crs(rec[28:17]), .o_rec_trl_fine(rec[16:12]),
    .o_rec_trl_crs(rec[11:0]), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .o_irq(irq));
  htc_arb_model arb (.i_clk_sys(clk), .i_reset(rst), .i_wr_req(req), .i_rec(rec), .i_stall(stall),
    .i_delay(dly), .o_wr_grant(grant));
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  function automatic logic [31:0] th(input int n);
    return (n >= 32) ? 32'hFFFFFFFF : (32'h1 << n) - 32'h1;
  endfunction : th
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    chk("pready", 1, k < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  task pulse(input int lf, input int tf, input int w);
    @(posedge clk);
    hit <= 1'b1;
    taps <= th(lf);
    repeat (w) @(posedge clk);
    hit <= 1'b0;
    taps <= th(tf);
    @(posedge clk);
    taps <= 32'h0;
    repeat (2) @(posedge clk);
  endtask : pulse
  task crec(input logic [1:0] k, input logic [4:0] lf, input logic [4:0] tf, input logic [11:0] dc);
    int n;
    n = 0;
    while (arb.rec_q.size() == 0 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    r = '0;
    if (n < 200) begin
      r = arb.rec_q.pop_front();
    end
    chk("record present", 1, n < 200);
    chk("channel", CH, r[40:36]);
    chk("kind", k, r[35:34]);
    chk("first fine", lf, r[33:29]);
    chk("trail fine", tf, r[16:12]);
    chk("coarse", dc, (k == 2'h0) ? 12'(r[11:0] - r[28:17]) : r[11:0]);
  endtask : crec
  task end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    int e;
    int t;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `HTC_ADDR_CTRL, 32'h0);
    chk("ctrl reset", 32'h10, rd);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped read", 32'h0, rd);
    chk("unmapped error", 1, err);
    apb(1'b1, `HTC_ADDR_OFFSET, 32'h123);
    apb(1'b1, `HTC_ADDR_CTRL, 32'h110);
    apb(1'b0, `HTC_ADDR_INFO, 32'h0);
    chk("coarse preset", 1, rd[27:16] >= 12'h123 && rd[27:16] < 12'h12C);
    apb(1'b0, `HTC_ADDR_CTRL, 32'h0);
    chk("reload self clears", 32'h10, rd);
    apb(1'b1, `HTC_ADDR_MASK, 32'h7);
    pulse(20, 5, 1);
    crec(2'h0, 5'd20, 5'd5, 12'd0);
    pulse(32, 16, 3);
    crec(2'h0, 5'd31, 5'd16, 12'd3);
    apb(1'b0, `HTC_ADDR_STATUS, 32'h0);
    chk("status stored and granted", 32'h5, rd);
    chk("irq raised", 1, irq);
    apb(1'b1, `HTC_ADDR_STATUS, 32'h7);
    chk("irq cleared", 0, irq);
    repeat (20) @(posedge clk);
    chk("no hit no record", 0, {req, arb.rec_q.size() != 0});
    stall <= 1'b1;
    pulse(17, 18, 2);
    pulse(19, 20, 2);
    pulse(21, 22, 2);
    apb(1'b0, `HTC_ADDR_INFO, 32'h0);
    chk("buffer count", 32'h4, rd[2:0]);
    apb(1'b0, `HTC_ADDR_STATUS, 32'h0);
    chk("drop flagged", 32'h3, rd);
    chk("request held", 1, req);
    apb(1'b1, `HTC_ADDR_MASK, 32'h0);
    chk("irq masked", 0, irq);
    apb(1'b1, `HTC_ADDR_MASK, 32'h2);
    chk("irq on drop", 1, irq);
    apb(1'b1, `HTC_ADDR_STATUS, 32'h7);
    dly <= 4'h3;
    stall <= 1'b0;
    crec(2'h0, 5'd17, 5'd18, 12'd2);
    crec(2'h0, 5'd19, 5'd20, 12'd2);
    repeat (20) @(posedge clk);
    chk("dropped hit absent", 0, {req, arb.rec_q.size() != 0});
    for (int m = 1; m < 4; m++) begin
      apb(1'b1, `HTC_ADDR_CTRL, 32'h10 | m);
      stall <= 1'b1;
      for (int i = 0; i < 3; i++) begin
        pulse(2 + i, 8 + i, 1);
      end
      apb(1'b0, `HTC_ADDR_INFO, 32'h0);
      chk("single edge count", (m == 3) ? 4 : 3, rd[2:0]);
      stall <= 1'b0;
      for (int i = 0; i < ((m == 3) ? 4 : 3); i++) begin
        e = (m == 3) ? i / 2 : i;
        t = (m == 2) || (m == 3 && i % 2 == 1);
        crec(t ? 2'h2 : 2'h1, 5'(t ? 8 + e : 2 + e), 5'd0, 12'd0);
      end
    end
    apb(1'b1, `HTC_ADDR_CTRL, 32'h14);
    pulse(5, 9, 1);
    crec(2'h0, 5'd10, 5'd18, 12'd2);
    apb(1'b1, `HTC_ADDR_CTRL, 32'h18);
    pulse(6, 12, 1);
    crec(2'h0, 5'd12, 5'd24, 12'd2);
    chk("request kept to grant", 0, arb.n_drop);
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end
endmodule : tb_hit_time_capture_channel_buffer
`default_nettype wire
